/* File: nlpt_top.sv */
`timescale 1ns/1ps
// What this block does
// - Products AND selected, optionally inverted channel levels
// - At most one edge channel per product
// - Function is OR of two products
// - Edge direction rising, falling or either
// - Nested: A arms, next B triggers
// - Filter: level function must persist filter time
// - Filter time programmable zero to 300 ns
// - Functions with an edge bypass filter
// - Gate rises when A arms
// - External reset returns armed block to idle
// - Gate falls with trigger on B
// - Two functions, either selectable outside nested

module nlpt_top import nlpt_pkg::*; (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [APB_AW-1:0] paddr_i,
    input wire logic [APB_DW-1:0] pwdata_i,
    output logic [APB_DW-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Logic pins of the system under test
    input wire logic [CHAN_N-1:0] chan_i,
    input wire logic ext_abort_i,
    // Outputs to downstream timing units
    output logic trig_o,
    output logic gate_o,
    output logic trigger_monitor_trace_o,
    output logic irq_o
);

    // ****************************************
    // Declarations
    // ****************************************
    typedef enum {ST_IDLE, ST_ARMED} nlpt_state_t;

    // Pin synchronisers
    logic [CHAN_N-1:0] chan_s1_d, chan_s1_q; // First stage, read only by second
    logic [CHAN_N-1:0] chan_s2_d, chan_s2_q; // Stable levels
    logic [CHAN_N-1:0] chan_pv_d, chan_pv_q; // Levels one cycle older, for edges
    logic abort_s1_d, abort_s1_q; // External reset, first stage
    logic abort_s2_d, abort_s2_q; // External reset, stable

    // Register file
    logic [CTRL_W-1:0] ctrl_d, ctrl_q; // Mode bits
    logic [FILT_W-1:0] filt_d, filt_q; // Filter time in cycles
    nlpt_func_t fa_d, fa_q; // Function A
    nlpt_func_t fb_d, fb_q; // Function B
    logic [EV_W-1:0] istat_d, istat_q; // Sticky events
    logic [EV_W-1:0] imask_d, imask_q; // Event mask
    logic [APB_DW-1:0] prdata_d, prdata_q; // Read data
    logic pready_d, pready_q; // Access phase answer
    logic pslverr_d, pslverr_q; // Unmapped address
    logic irq_d, irq_q; // Interrupt level

    // Sequencer
    nlpt_state_t state_d, state_q; // Idle or armed
    logic gate_d, gate_q; // Armed-interval gate
    logic trig_d, trig_q; // Trigger pulse
    logic trace_d, trace_q; // Monitor trace level
    logic [EV_W-1:0] ev; // Events this cycle

    // Decode helpers
    logic access; // Access phase in progress
    logic wr_en; // Write takes effect this edge
    logic rec_a, rec_b; // Recognitions of A and B
    logic qual_a, qual_b; // Qualified levels of A and B
    logic nested, sel_b, filt_en; // Control fields

    // ****************************************
    // Helper functions
    // ****************************************
    // Is the byte address one of ours
    function automatic logic addr_ok(input logic [APB_AW-1:0] a);
        case (a)
            REG_CTRL, REG_FILT, REG_FA0, REG_FA1, REG_FB0, REG_FB1,
            REG_STATE, REG_ISTAT, REG_IMASK: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : addr_ok

    // Product config from write data
    function automatic nlpt_prod_t prod_of(input logic [APB_DW-1:0] w);
        return nlpt_prod_t'(w[PROD_W-1:0]);
    endfunction : prod_of

    // Product config widened to a bus word
    function automatic logic [APB_DW-1:0] word_of(input nlpt_prod_t p);
        return {{(APB_DW-PROD_W){1'b0}}, p};
    endfunction : word_of

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Two stages before any logic looks at a pin
    always_comb begin
        chan_s1_d = chan_i;
        chan_s2_d = chan_s1_q;
        chan_pv_d = chan_s2_q;
        abort_s1_d = ext_abort_i;
        abort_s2_d = abort_s1_q;
    end

    // Synchroniser flops
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            chan_s1_q <= 4'h0;
            chan_s2_q <= 4'h0;
            chan_pv_q <= 4'h0;
            abort_s1_q <= 1'b0;
            abort_s2_q <= 1'b0;
        end else begin
            chan_s1_q <= chan_s1_d;
            chan_s2_q <= chan_s2_d;
            chan_pv_q <= chan_pv_d;
            abort_s1_q <= abort_s1_d;
            abort_s2_q <= abort_s2_d;
        end
    end

    // ****************************************
    // Function evaluators
    // ****************************************
    assign nested = ctrl_q[CTRL_NESTED_BIT];
    assign sel_b = ctrl_q[CTRL_SEL_B_BIT];
    assign filt_en = ctrl_q[CTRL_FILT_EN_BIT];

    // Function A
    nlpt_func_eval u_func_a (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .lvl_i(chan_s2_q),
        .prev_i(chan_pv_q),
        .cfg_i(fa_q),
        .filt_en_i(filt_en),
        .filt_cyc_i(filt_q),
        .qual_o(qual_a),
        .recog_o(rec_a)
    );

    // Function B, same filter setting
    nlpt_func_eval u_func_b (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .lvl_i(chan_s2_q),
        .prev_i(chan_pv_q),
        .cfg_i(fb_q),
        .filt_en_i(filt_en),
        .filt_cyc_i(filt_q),
        .qual_o(qual_b),
        .recog_o(rec_b)
    );

    // ****************************************
    // Trigger sequencer
    // ****************************************
    // Next state, gate, trigger and events
    always_comb begin
        state_d = state_q;
        gate_d = gate_q;
        trig_d = 1'b0;
        ev = EV_RST;
        if (abort_s2_q) begin
            // External reset wins over any recognition
            state_d = ST_IDLE;
            gate_d = 1'b0;
            ev[EV_ABORT_BIT] = (state_q == ST_ARMED);
        end else if (nested) begin
            case (state_q)
                ST_IDLE: begin
                    // A arms and opens the gate
                    if (rec_a) begin
                        state_d = ST_ARMED;
                        gate_d = 1'b1;
                        ev[EV_ARM_BIT] = 1'b1;
                    end
                end
                ST_ARMED: begin
                    // First B after arming fires and closes the gate
                    if (rec_b) begin
                        state_d = ST_IDLE;
                        gate_d = 1'b0;
                        trig_d = 1'b1;
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                    gate_d = 1'b0;
                end
            endcase
        end else begin
            // Single function mode, selected function fires
            state_d = ST_IDLE;
            gate_d = 1'b0;
            trig_d = sel_b ? rec_b : rec_a;
        end
        ev[EV_TRIG_BIT] = trig_d;
        // Trace follows the function currently awaited
        if (nested) begin
            trace_d = (state_q == ST_ARMED) ? qual_b : qual_a;
        end else begin
            trace_d = sel_b ? qual_b : qual_a;
        end
    end

    // Sequencer flops; trigger lasts exactly one cycle in nested mode
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            state_q <= ST_IDLE;
            gate_q <= 1'b0;
            trig_q <= 1'b0;
            trace_q <= 1'b0;
        end else begin
            state_q <= state_d;
            gate_q <= gate_d;
            trig_q <= trig_d;
            trace_q <= trace_d;
        end
    end

    // ****************************************
    // APB slave and registers
    // ****************************************
    // One wait state: read data is latched in the first access cycle
    always_comb begin
        access = psel_i & penable_i;
        wr_en = access & pready_q & pwrite_i & addr_ok(paddr_i);
        pready_d = access & ~pready_q;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        if (access && !pready_q) begin
            pslverr_d = ~addr_ok(paddr_i);
            case (paddr_i)
                REG_CTRL: prdata_d = {{(APB_DW-CTRL_W){1'b0}}, ctrl_q};
                REG_FILT: prdata_d = {{(APB_DW-FILT_W){1'b0}}, filt_q};
                REG_FA0: prdata_d = word_of(fa_q.p0);
                REG_FA1: prdata_d = word_of(fa_q.p1);
                REG_FB0: prdata_d = word_of(fb_q.p0);
                REG_FB1: prdata_d = word_of(fb_q.p1);
                REG_STATE: prdata_d = {29'h0, trace_q, gate_q, state_q == ST_ARMED};
                REG_ISTAT: prdata_d = {{(APB_DW-EV_W){1'b0}}, istat_q};
                REG_IMASK: prdata_d = {{(APB_DW-EV_W){1'b0}}, imask_q};
                default: prdata_d = 32'h0;
            endcase
        end
        ctrl_d = ctrl_q;
        filt_d = filt_q;
        fa_d = fa_q;
        fb_d = fb_q;
        imask_d = imask_q;
        istat_d = istat_q;
        if (wr_en) begin
            case (paddr_i)
                REG_CTRL: ctrl_d = pwdata_i[CTRL_W-1:0];
                // Longer settings clamp to the longest filter time
                REG_FILT: filt_d = (pwdata_i[FILT_W-1:0] > FILT_MAX_CYC) ? FILT_MAX_CYC : pwdata_i[FILT_W-1:0];
                REG_FA0: fa_d.p0 = prod_of(pwdata_i);
                REG_FA1: fa_d.p1 = prod_of(pwdata_i);
                REG_FB0: fb_d.p0 = prod_of(pwdata_i);
                REG_FB1: fb_d.p1 = prod_of(pwdata_i);
                REG_ISTAT: istat_d = istat_q & ~pwdata_i[EV_W-1:0];
                REG_IMASK: imask_d = pwdata_i[EV_W-1:0];
                default: ctrl_d = ctrl_q; // State register ignores writes
            endcase
        end
        // A new event beats a clear in the same cycle
        istat_d = istat_d | ev;
        irq_d = |(istat_q & imask_q);
    end

    // Register flops
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            ctrl_q <= CTRL_RST;
            filt_q <= FILT_RST;
            fa_q <= {PROD_RST, PROD_RST};
            fb_q <= {PROD_RST, PROD_RST};
            istat_q <= EV_RST;
            imask_q <= EV_RST;
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            filt_q <= filt_d;
            fa_q <= fa_d;
            fb_q <= fb_d;
            istat_q <= istat_d;
            imask_q <= imask_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            irq_q <= irq_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign trig_o = trig_q;
    assign gate_o = gate_q;
    assign trigger_monitor_trace_o = trace_q;
    assign irq_o = irq_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    // Armed and B recognised with no reset pending
    sequence s_fire;
        state_q == ST_ARMED && nested && rec_b && !abort_s2_q;
    endsequence

    // Idle in nested mode and A recognised
    sequence s_arm;
        state_q == ST_IDLE && nested && rec_a && !abort_s2_q;
    endsequence

    a_arm_gate: assert property (s_arm |=> gate_q && state_q == ST_ARMED && !trig_q)
        else $error("gate did not rise on arming");
    a_fire_drop: assert property (s_fire |=> trig_q && !gate_q ##1 !trig_q)
        else $error("B did not fire and close gate");
    a_idle_quiet: assert property (nested && state_q == ST_IDLE && $stable(ctrl_q) |=> !trig_q)
        else $error("trigger without prior arming");
    a_abort_idle: assert property (abort_s2_q |=> !gate_q && !trig_q && state_q == ST_IDLE)
        else $error("external reset did not return to idle");
    a_abort_wins: assert property (abort_s2_q && rec_b |=> !trig_q)
        else $error("trigger issued despite same-cycle reset");
    a_single_sel: assert property (!nested && !abort_s2_q && (sel_b ? rec_b : rec_a) |=> trig_q)
        else $error("selected function did not fire");
    a_filt_range: assert property (filt_q <= FILT_MAX_CYC)
        else $error("filter time beyond longest setting");
    a_irq_level: assert property (|(istat_q & imask_q) |=> irq_o)
        else $error("interrupt not raised for unmasked event");

endmodule : nlpt_top

/* File: nlpt_pkg.sv */
package nlpt_pkg;

    // ****************************************
    // Bus geometry
    // ****************************************
    localparam int APB_AW = 8; // Byte address width
    localparam int APB_DW = 32; // Data width

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [APB_AW-1:0] REG_CTRL = 8'h00; // Mode and filter enable
    localparam logic [APB_AW-1:0] REG_FILT = 8'h04; // Filter time in cycles
    localparam logic [APB_AW-1:0] REG_FA0 = 8'h08; // Function A, product 0
    localparam logic [APB_AW-1:0] REG_FA1 = 8'h0C; // Function A, product 1
    localparam logic [APB_AW-1:0] REG_FB0 = 8'h10; // Function B, product 0
    localparam logic [APB_AW-1:0] REG_FB1 = 8'h14; // Function B, product 1
    localparam logic [APB_AW-1:0] REG_STATE = 8'h18; // Live state, read only
    localparam logic [APB_AW-1:0] REG_ISTAT = 8'h1C; // Sticky events, write one to clear
    localparam logic [APB_AW-1:0] REG_IMASK = 8'h20; // Event mask, one enables

    // ****************************************
    // Control fields and reset values
    // ****************************************
    localparam int CTRL_W = 3; // Control register width
    localparam int CTRL_NESTED_BIT = 0; // One selects A-then-B mode
    localparam int CTRL_SEL_B_BIT = 1; // Active function outside nested mode
    localparam int CTRL_FILT_EN_BIT = 2; // Duration filter enable
    localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0; // Single function A, filter off

    // State register fields
    localparam int ST_ARMED_BIT = 0; // Armed, waiting for B
    localparam int ST_GATE_BIT = 1; // Gate output level
    localparam int ST_TRACE_BIT = 2; // Monitor trace level

    // Event bits, shared by status and mask registers
    localparam int EV_W = 3; // Number of events
    localparam int EV_TRIG_BIT = 0; // Trigger pulse issued
    localparam int EV_ARM_BIT = 1; // Function A armed the block
    localparam int EV_ABORT_BIT = 2; // External reset while armed
    localparam logic [EV_W-1:0] EV_RST = 3'h0; // Status and mask reset

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ = 40; // Sampling clock rate
    localparam int FILT_MAX_NS = 300; // Longest filter time
    localparam int FILT_W = 4; // Filter count width
    localparam logic [FILT_W-1:0] FILT_MAX_CYC = FILT_W'((FILT_MAX_NS * CLK_MHZ) / 1000);
    localparam logic [FILT_W-1:0] FILT_RST = 4'h0; // Filter off at reset

    // ****************************************
    // Product term configuration
    // ****************************************
    localparam int CHAN_N = 4; // Logic input channels
    localparam logic [1:0] EDGE_RISE = 2'h1; // Rising transition
    localparam logic [1:0] EDGE_FALL = 2'h2; // Falling transition
    localparam logic [1:0] EDGE_ANY = 2'h3; // Either transition

    typedef struct packed {
        logic [1:0] edge_dir; // Bits 13:12, rise/fall/either
        logic [1:0] edge_ch; // Bits 11:10, edge-sensitive channel
        logic edge_en; // Bit 9, one channel on its edge
        logic term_en; // Bit 8, product takes part
        logic [CHAN_N-1:0] inv; // Bits 7:4, invert channel level
        logic [CHAN_N-1:0] use_m; // Bits 3:0, channel takes part
    } nlpt_prod_t;

    localparam int PROD_W = 14; // Packed width of a product
    localparam nlpt_prod_t PROD_RST = '0; // Product disabled

    typedef struct packed {
        nlpt_prod_t p1; // Second product
        nlpt_prod_t p0; // First product
    } nlpt_func_t;

endpackage : nlpt_pkg

/* File: nlpt_func_eval.sv */
`timescale 1ns/1ps

module nlpt_func_eval import nlpt_pkg::*; (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic [CHAN_N-1:0] lvl_i, // Synchronised levels, this cycle
    input wire logic [CHAN_N-1:0] prev_i, // Levels one cycle earlier
    input wire nlpt_func_t cfg_i, // Two product terms
    input wire logic filt_en_i, // Duration filter enable
    input wire logic [FILT_W-1:0] filt_cyc_i, // Required persistence in cycles
    output logic qual_o, // Qualified condition level
    output logic recog_o // One pulse per recognition
);

    // ****************************************
    // Product evaluation
    // ****************************************
    // AND of selected levels, one channel optionally on its edge
    function automatic logic prod_eval(input nlpt_prod_t c, input logic [CHAN_N-1:0] lv,
                                       input logic [CHAN_N-1:0] pv);
        logic [CHAN_N-1:0] m;
        logic rise;
        logic fall;
        logic ed;
        m = (lv ^ c.inv) | ~c.use_m;
        if (c.edge_en) begin
            m[c.edge_ch] = 1'b1; // Edge channel not taken on level
        end
        rise = lv[c.edge_ch] & ~pv[c.edge_ch];
        fall = ~lv[c.edge_ch] & pv[c.edge_ch];
        ed = ~c.edge_en | (c.edge_dir[0] & rise) | (c.edge_dir[1] & fall);
        return c.term_en & (&m) & ed;
    endfunction : prod_eval

    logic has_edge; // Function holds an edge term
    logic cond; // Raw function value
    logic qual; // Condition after the filter
    logic [FILT_W-1:0] cnt_d, cnt_q; // Persistence counter
    logic qual_d, qual_q; // Qualified level, registered
    logic recog_d, recog_q; // Recognition pulse

    // ****************************************
    // Condition and filter
    // ****************************************
    // Next values of counter and recognition
    always_comb begin
        has_edge = (cfg_i.p0.term_en & cfg_i.p0.edge_en) | (cfg_i.p1.term_en & cfg_i.p1.edge_en);
        cond = prod_eval(cfg_i.p0, lvl_i, prev_i) | prod_eval(cfg_i.p1, lvl_i, prev_i);
        // Counter clears the moment the condition drops
        if (!cond) begin
            cnt_d = FILT_RST;
        end else if (cnt_q < FILT_MAX_CYC) begin
            cnt_d = cnt_q + 4'h1;
        end else begin
            cnt_d = cnt_q; // Saturate at the longest time
        end
        // Edge functions skip the filter
        qual = cond & (has_edge | ~filt_en_i | (filt_cyc_i == FILT_RST) | (cnt_q >= filt_cyc_i));
        qual_d = qual;
        // Level functions give one pulse per true interval
        recog_d = qual & (has_edge | ~qual_q);
    end

    // Register stage
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            cnt_q <= FILT_RST;
            qual_q <= 1'b0;
            recog_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            qual_q <= qual_d;
            recog_q <= recog_d;
        end
    end

    assign qual_o = qual_q;
    assign recog_o = recog_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    a_cnt_clears: assert property (!cond |=> cnt_q == FILT_RST)
        else $error("filter counter did not clear");
    a_edge_bypass: assert property (has_edge && cond |=> recog_o)
        else $error("edge function was held by filter");
    a_filter_holds: assert property (filt_en_i && !has_edge && filt_cyc_i != FILT_RST &&
                                     cnt_q < filt_cyc_i |=> !recog_o)
        else $error("level function recognised before filter time");
    a_level_and: assert property (cfg_i.p0.term_en && !cfg_i.p0.edge_en &&
                                  ((lvl_i ^ cfg_i.p0.inv) | ~cfg_i.p0.use_m) == 4'hF |-> cond)
        else $error("satisfied product did not make function true");

endmodule : nlpt_func_eval

/* File: nlpt_sut_model.sv */
`timescale 1ns/1ps
// ****************************************
// System under test: drives logic pins and the external reset
// ****************************************
module nlpt_sut_model import nlpt_pkg::*; (
    input wire logic ref_clk_i,
    input wire logic [CHAN_N-1:0] lvl_i, // Levels the bench asks for
    input wire logic abort_i, // Bench asks the timing unit to reset the block
    output logic [CHAN_N-1:0] chan_o, // Logic pins
    output logic ext_abort_o // Reset from downstream unit
);
    // Pins change just after an edge, like real logic after its own clock
    always_ff @(posedge ref_clk_i) begin
        chan_o <= lvl_i;
        ext_abort_o <= abort_i;
    end
endmodule : nlpt_sut_model

/* File: test_nlpt_top.sv */
`timescale 1ns/1ps
module test_nlpt_top import nlpt_pkg::*; ;
    logic ref_clk_i = 1'b0;
    logic rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, abort_req = 1'b0;
    logic [APB_AW-1:0] paddr = '0;
    logic [APB_DW-1:0] pwdata = '0, prdata, rdat;
    logic pready, pslverr, rerr, trig, gate, trace, irq, ext_abort;
    logic [CHAN_N-1:0] lvl = '0, chan;
    int num_errors = 0, checks_done = 0, tc;
    always #12.5 ref_clk_i = ~ref_clk_i; // 40 MHz
    nlpt_sut_model sut_u (.ref_clk_i(ref_clk_i), .lvl_i(lvl), .abort_i(abort_req), .chan_o(chan),
        .ext_abort_o(ext_abort));
    nlpt_top dut_u (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .chan_i(chan), .ext_abort_i(ext_abort), .trig_o(trig), .gate_o(gate),
        .trigger_monitor_trace_o(trace), .irq_o(irq));
    // ****************************************
    // Shared tasks
    // ****************************************
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task wrap_up;
        if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    // One APB transfer; an idle edge at the end keeps drivers single per step
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            wrap_up();
        end
        @(posedge ref_clk_i);
    endtask : apb
    // Count trigger pulses over a number of cycles
    task cnt(input int cyc);
        repeat (cyc) begin
            @(posedge ref_clk_i);
            if (trig === 1'b1) tc++;
        end
    endtask : cnt
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge ref_clk_i);
        rst_b <= 1'b1;
        @(posedge ref_clk_i);
        apb(1'b0, REG_CTRL, 32'h0);
        check("ctrl", rdat, 32'h0);
        apb(1'b1, REG_FILT, 32'hF);
        apb(1'b0, REG_FILT, 32'h0);
        check("filt", rdat, FILT_MAX_CYC);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped", rerr, 32'h1);
        // Level product: not ch0 and ch1
        apb(1'b1, REG_FA0, 32'h113);
        tc = 0;
        lvl <= 4'h3;
        cnt(10);
        check("inv", tc, 32'h0);
        lvl <= 4'h2;
        cnt(10);
        check("level", tc, 32'h1);
        check("trace", trace, 32'h1);
        lvl <= 4'h0;
        // Edge direction on ch2 through function B
        apb(1'b1, REG_CTRL, 32'h2);
        for (int d = 1; d <= 3; d++) begin
            apb(1'b1, REG_FB0, 32'h0B00 | (d << 12));
            tc = 0;
            lvl <= 4'h4;
            cnt(8);
            lvl <= 4'h0;
            cnt(8);
            check("edge", tc, (d == 3) ? 32'h2 : 32'h1);
        end
        apb(1'b1, REG_FB1, 32'h1F00);
        tc = 0;
        lvl <= 4'h8;
        cnt(8);
        check("second", tc, 32'h1);
        lvl <= 4'h0;
        // Filter on A: 3 samples refused, 4 accepted
        apb(1'b1, REG_FILT, 32'h3);
        apb(1'b1, REG_CTRL, 32'h4);
        tc = 0;
        lvl <= 4'h2;
        cnt(3);
        lvl <= 4'h0;
        cnt(10);
        check("short", tc, 32'h0);
        lvl <= 4'h2;
        cnt(4);
        lvl <= 4'h0;
        cnt(10);
        check("long", tc, 32'h1);
        apb(1'b1, REG_CTRL, 32'h6);
        tc = 0;
        lvl <= 4'h8;
        cnt(6);
        check("bypass", tc, 32'h1);
        lvl <= 4'h0;
        // Nested A then B with interrupts
        apb(1'b1, REG_CTRL, 32'h1);
        apb(1'b1, REG_IMASK, 32'h3);
        tc = 0;
        lvl <= 4'h2;
        cnt(6);
        check("gate_up", gate, 32'h1);
        check("armed_only", tc, 32'h0);
        apb(1'b0, REG_STATE, 32'h0);
        check("state", rdat, 32'h3);
        check("irq", irq, 32'h1);
        lvl <= 4'h6;
        cnt(6);
        check("fire", tc, 32'h1);
        check("gate_dn", gate, 32'h0);
        lvl <= 4'h0;
        cnt(4);
        apb(1'b0, REG_ISTAT, 32'h0);
        check("istat", rdat, 32'h3);
        apb(1'b1, REG_ISTAT, 32'h7);
        apb(1'b0, REG_ISTAT, 32'h0);
        check("clear", rdat, 32'h0);
        check("irq0", irq, 32'h0);
        // External reset while armed
        lvl <= 4'h2;
        cnt(6);
        abort_req <= 1'b1;
        tc = 0;
        cnt(6);
        check("abort", gate, 32'h0);
        abort_req <= 1'b0;
        lvl <= 4'h0;
        cnt(4);
        lvl <= 4'h4;
        cnt(6);
        check("idle", tc, 32'h0);
        apb(1'b0, REG_ISTAT, 32'h0);
        check("ev", rdat, 32'h6);
        // Re-arm, then a B edge meets the external reset in one cycle: reset wins
        lvl <= 4'h6;
        cnt(6);
        check("rearm", gate, 32'h1);
        tc = 0;
        lvl <= 4'h2;
        // Reset one cycle behind the edge so both reach the sequencer together
        cnt(1);
        abort_req <= 1'b1;
        cnt(8);
        check("abort_b", tc, 32'h0);
        check("abort_g", gate, 32'h0);
        abort_req <= 1'b0;
        wrap_up();
    end
endmodule : test_nlpt_top
